/* design/nfc_pwm_mode_ctrl.sv */
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nfc_pwm_mode_ctrl #(
  parameter logic [63:0] HOUR_CYCLES   = nfc_pwm_pkg::HOUR_CYCLES_DEF,
  parameter int          SAVE_HOURS    = nfc_pwm_pkg::SAVE_INTERVAL_HOURS,
  parameter bit          AGING_PRESENT = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  module_supply,
  input  wire logic                  field_present,
  input  wire nfc_pwm_pkg::link_in_t link_in,
  output var  logic                  resp_data,
  output var  logic                  resp_en,
  output var  logic                  pwm_out,
  output var  logic                  pwm_oe,
  output var  logic                  config_mode,
  output var  logic                  lighting_mode,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output var  logic [31:0]           dat_o,
  output var  logic                  ack_o
);
  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       link_clk_q;
  logic       frame_q;
  wire  [4:0] raw = {module_supply, field_present, link_in.clk,
                     link_in.frame, link_in.data};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1      <= '0;
      sync2      <= '0;
      link_clk_q <= 1'b0;
      frame_q    <= 1'b0;
    end else begin
      sync1      <= raw;
      sync2      <= sync1;
      link_clk_q <= sync2[2];
      frame_q    <= sync2[1];
    end
  end
  wire supply_ok = sync2[4];
  wire field_on  = sync2[3];
  wire link_rise = sync2[2] & ~link_clk_q;
  wire frame_on  = sync2[1];
  wire frame_end = frame_q & ~sync2[1];
  wire bit_in    = sync2[0];

  // ---------------------------------------------
  // mode control
  // ---------------------------------------------
  nfc_pwm_pkg::mode_t mode;
  nfc_pwm_pkg::mode_t next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      nfc_pwm_pkg::MODE_OFF: begin
        if (supply_ok) begin
          next_mode = nfc_pwm_pkg::MODE_BOOT; // RQ5
        end else if (field_on) begin
          next_mode = nfc_pwm_pkg::MODE_CONFIG; // RQ1
        end
      end
      nfc_pwm_pkg::MODE_CONFIG: begin
        // supply arriving during config waits for the field to go
        if (!field_on) begin
          next_mode = nfc_pwm_pkg::MODE_OFF; // RQ2 RQ3
        end
      end
      nfc_pwm_pkg::MODE_BOOT: next_mode = nfc_pwm_pkg::MODE_LIGHT;
      nfc_pwm_pkg::MODE_LIGHT: begin
        if (!supply_ok) begin
          next_mode = nfc_pwm_pkg::MODE_SAVE; // RQ11
        end
      end
      nfc_pwm_pkg::MODE_SAVE: next_mode = nfc_pwm_pkg::MODE_OFF;
    endcase
  end
  wire in_config = mode == nfc_pwm_pkg::MODE_CONFIG;
  wire in_light  = mode == nfc_pwm_pkg::MODE_LIGHT;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode          <= nfc_pwm_pkg::MODE_OFF;
      pwm_oe        <= 1'b0;
      config_mode   <= 1'b0;
      lighting_mode <= 1'b0;
    end else begin
      mode          <= next_mode;
      pwm_oe        <= next_mode == nfc_pwm_pkg::MODE_LIGHT; // RQ4
      config_mode   <= next_mode == nfc_pwm_pkg::MODE_CONFIG; // RQ21
      lighting_mode <= next_mode == nfc_pwm_pkg::MODE_LIGHT;
    end
  end

  // ---------------------------------------------
  // block memory
  // ---------------------------------------------
  logic [31:0]          nvm [nfc_pwm_pkg::NUM_BLOCKS];
  nfc_pwm_pkg::mem_wr_t wr;
  nfc_pwm_pkg::mem_wr_t cmd_wr;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < nfc_pwm_pkg::NUM_BLOCKS; i++) begin
        nvm[i] <= '0;
      end
    end else if (wr.en) begin
      nvm[wr.addr] <= wr.data;
    end
  end

  // ---------------------------------------------
  // operating hours and power cycles
  // ---------------------------------------------
  logic [63:0] presc;
  logic [31:0] hours;
  logic [7:0]  since_save;
  wire hour_tick = in_light && presc == HOUR_CYCLES - 64'h1; // RQ24
  wire save_due  = hour_tick && since_save == 8'(SAVE_HOURS - 1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc      <= '0;
      hours      <= '0;
      since_save <= '0;
    end else if (mode == nfc_pwm_pkg::MODE_BOOT) begin
      presc      <= '0;
      hours      <= nvm[nfc_pwm_pkg::HOURS_BLOCK];
      since_save <= '0;
    end else if (hour_tick) begin
      presc      <= '0;
      hours      <= hours + 32'h1; // RQ10
      since_save <= save_due ? 8'h00 : since_save + 8'h01;
    end else if (in_light) begin
      presc <= presc + 64'h1;
    end
  end
  always_comb begin
    wr = '0;
    unique case (mode)
      nfc_pwm_pkg::MODE_BOOT: begin
        wr.en   = 1'b1; // RQ12
        wr.addr = nfc_pwm_pkg::CYCLES_BLOCK;
        wr.data = nvm[nfc_pwm_pkg::CYCLES_BLOCK] + 32'h1;
      end
      nfc_pwm_pkg::MODE_SAVE: begin
        wr.en   = 1'b1; // RQ11
        wr.addr = nfc_pwm_pkg::HOURS_BLOCK;
        wr.data = hours;
      end
      nfc_pwm_pkg::MODE_LIGHT: begin
        wr.en   = save_due; // RQ10 RQ24
        wr.addr = nfc_pwm_pkg::HOURS_BLOCK;
        wr.data = hours + 32'h1;
      end
      nfc_pwm_pkg::MODE_CONFIG: wr = cmd_wr;
      nfc_pwm_pkg::MODE_OFF: wr = '0;
    endcase
  end

  // ---------------------------------------------
  // setpoint and aging interpolation
  // ---------------------------------------------
  logic        aging_en;
  logic [15:0] base_period;
  logic [15:0] base_duty;
  logic [15:0] set_period;
  logic [15:0] set_duty;
  logic [nfc_pwm_pkg::NUM_REFS-1:0] reached;
  wire [15:0] hr16 = |hours[31:16] ? 16'hFFFF : hours[15:0];
  genvar g;
  generate
    for (g = 0; g < nfc_pwm_pkg::NUM_REFS; g++) begin : g_ref
      assign reached[g] = hr16 >= nvm[g + 1][31:16];
    end
  endgenerate
  logic [2:0] seg;
  always_comb begin
    seg = '0;
    for (int i = 0; i < nfc_pwm_pkg::NUM_REFS; i++) begin
      if (reached[i]) begin
        seg = 3'(i);
      end
    end
  end
  wire [4:0]  lo_blk = nfc_pwm_pkg::REF_BASE + 5'(seg);
  wire [4:0]  hi_blk = lo_blk + 5'h1;
  wire [15:0] h0     = nvm[lo_blk][31:16];
  wire [15:0] d0     = nvm[lo_blk][15:0];
  wire [15:0] h1     = nvm[hi_blk][31:16];
  wire [15:0] d1     = nvm[hi_blk][15:0];
  wire        flat   = seg == 3'h7 || h1 <= h0;
  wire signed [17:0] delta = 18'(d1) - 18'(d0);
  wire signed [17:0] span  = 18'(h1 - h0);
  wire signed [17:0] pos   = 18'(hr16 - h0);
  wire signed [35:0] prod  = delta * pos;
  wire signed [35:0] step  = flat ? 36'sh0 : prod / 36'(span);
  wire [15:0] interp = !reached[0] ? base_duty : d0 + step[15:0]; // RQ13
  wire aging_on = AGING_PRESENT && aging_en; // RQ14
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base_period <= '0;
      base_duty   <= '0;
      set_period  <= '0;
      set_duty    <= '0;
    end else if (mode == nfc_pwm_pkg::MODE_BOOT) begin
      base_period <= nvm[nfc_pwm_pkg::CFG_BLOCK][31:16]; // RQ6
      base_duty   <= nvm[nfc_pwm_pkg::CFG_BLOCK][15:0];
      set_period  <= nvm[nfc_pwm_pkg::CFG_BLOCK][31:16];
      set_duty    <= nvm[nfc_pwm_pkg::CFG_BLOCK][15:0];
    end else if (in_light) begin
      set_period <= base_period;
      set_duty   <= aging_on ? interp : base_duty; // RQ13
    end
  end
  pwm_gen #(.W(16)) u_pwm (
    .clk     (clk),
    .reset   (reset),
    .run     (next_mode == nfc_pwm_pkg::MODE_LIGHT), // RQ22 RQ4
    .period  (set_period),
    .duty    (set_duty),
    .pwm_out (pwm_out)
  );

  // ---------------------------------------------
  // frame receiver
  // ---------------------------------------------
  logic [63:0] rx_buf;
  logic [6:0]  rx_bits;
  logic        rx_over;
  logic        quiet;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_buf  <= '0;
      rx_bits <= '0;
      rx_over <= 1'b0;
    end else if (!in_config || frame_end) begin // RQ7
      rx_bits <= '0;
      rx_over <= 1'b0;
    end else if (frame_on && link_rise) begin
      if (rx_bits == nfc_pwm_pkg::RX_MAX_BITS) begin
        rx_over <= 1'b1;
      end else begin
        rx_buf[rx_bits[5:0]] <= bit_in;
        rx_bits              <= rx_bits + 7'h1;
      end
    end
  end
  wire [3:0]  rx_len  = rx_bits[6:3];
  wire        len_ok  = rx_bits[2:0] == 3'h0 && !rx_over;
  wire [7:0]  cmd     = rx_buf[15:8];
  wire [7:0]  p2      = rx_buf[23:16];
  wire [7:0]  cblk    = rx_buf[31:24];
  wire [7:0]  cidx    = rx_buf[39:32];
  wire [7:0]  cdat    = rx_buf[47:40];
  wire [31:0] wdata   = rx_buf[55:24];
  wire [31:0] locks   = nvm[nfc_pwm_pkg::LOCK_BLOCK[4:0]];
  wire        p2_lock = locks[{p2[3:0], 1'b0}];
  wire        cb_lock = locks[{cblk[3:0], 1'b0}];
  wire        afi_lck = |(locks & nfc_pwm_pkg::AFI_LOCK);

  // ---------------------------------------------
  // command decoder
  // ---------------------------------------------
  logic        answer;
  logic [7:0]  err;
  logic [3:0]  resp_bytes;
  logic [87:0] resp_buf;
  logic        set_quiet;
  logic        clr_quiet;
  logic [31:0] byte_word;
  always_comb begin
    answer     = 1'b0;
    err        = '0;
    resp_bytes = nfc_pwm_pkg::RESP_OK;
    resp_buf   = {80'h0, nfc_pwm_pkg::FLAG_OK};
    set_quiet  = 1'b0;
    clr_quiet  = 1'b0;
    cmd_wr     = '0;
    byte_word  = nvm[cblk[4:0]];
    byte_word[{cidx[1:0], 3'h0} +: 8] = cdat;
    if (in_config && frame_end && len_ok) begin // RQ7 RQ15
      unique case (cmd) // RQ16 RQ17
        nfc_pwm_pkg::CMD_INVENTORY: begin
          answer     = rx_len == nfc_pwm_pkg::LEN_ONE_PARAM && !quiet;
          resp_bytes = nfc_pwm_pkg::RESP_INV;
          resp_buf   = {8'h0, nvm[nfc_pwm_pkg::UID_HI],
                        nvm[nfc_pwm_pkg::UID_LO], nfc_pwm_pkg::DSFID,
                        nfc_pwm_pkg::FLAG_OK};
        end
        nfc_pwm_pkg::CMD_QUIET: begin
          set_quiet = rx_len == nfc_pwm_pkg::LEN_SHORT;
        end
        nfc_pwm_pkg::CMD_READ: begin
          answer = rx_len == nfc_pwm_pkg::LEN_ONE_PARAM;
          if (p2 > nfc_pwm_pkg::LOCK_BLOCK) begin
            err = nfc_pwm_pkg::ERR_NO_BLOCK;
          end else begin
            resp_bytes = nfc_pwm_pkg::RESP_READ;
            resp_buf   = {48'h0, nvm[p2[4:0]], nfc_pwm_pkg::FLAG_OK};
          end
        end
        nfc_pwm_pkg::CMD_WRITE: begin
          answer      = rx_len == nfc_pwm_pkg::LEN_BLOCK_WR;
          cmd_wr.addr = p2[4:0];
          // lock bits only ever set, never cleared
          if (p2 == nfc_pwm_pkg::LOCK_BLOCK) begin
            cmd_wr.en   = answer; // RQ20
            cmd_wr.data = locks | wdata;
          end else if (p2 >= nfc_pwm_pkg::USER_BLOCKS) begin
            err = nfc_pwm_pkg::ERR_NO_BLOCK; // RQ19
          end else if (p2_lock) begin
            err = nfc_pwm_pkg::ERR_LOCKED; // RQ20
          end else begin
            cmd_wr.en   = answer;
            cmd_wr.data = wdata;
          end
        end
        nfc_pwm_pkg::CMD_SELECT, nfc_pwm_pkg::CMD_READY: begin
          answer    = rx_len == nfc_pwm_pkg::LEN_SHORT;
          clr_quiet = answer;
        end
        nfc_pwm_pkg::CMD_WR_AFI: begin
          answer      = rx_len == nfc_pwm_pkg::LEN_ONE_PARAM;
          cmd_wr.addr = nfc_pwm_pkg::AFI_BLOCK;
          cmd_wr.data = {p2, nvm[nfc_pwm_pkg::AFI_BLOCK][23:0]};
          if (afi_lck) begin
            err = nfc_pwm_pkg::ERR_LOCKED;
          end else begin
            cmd_wr.en = answer;
          end
        end
        nfc_pwm_pkg::CMD_LOCK_AFI: begin
          answer      = rx_len == nfc_pwm_pkg::LEN_SHORT;
          cmd_wr.addr = nfc_pwm_pkg::LOCK_BLOCK[4:0];
          cmd_wr.data = locks | nfc_pwm_pkg::AFI_LOCK;
          if (afi_lck) begin
            err = nfc_pwm_pkg::ERR_LOCKED;
          end else begin
            cmd_wr.en = answer;
          end
        end
        nfc_pwm_pkg::CMD_CUSTOM: begin
          answer      = rx_len == nfc_pwm_pkg::LEN_BYTE_WR;
          cmd_wr.addr = cblk[4:0];
          cmd_wr.data = byte_word;
          if (p2 != nfc_pwm_pkg::SUB_BYTE_WR) begin
            err = nfc_pwm_pkg::ERR_UNSUP;
          end else if (cblk >= nfc_pwm_pkg::USER_BLOCKS) begin
            err = nfc_pwm_pkg::ERR_NO_BLOCK; // RQ19
          end else if (cidx > 8'h03) begin
            err = nfc_pwm_pkg::ERR_OTHER;
          end else if (cb_lock) begin
            err = nfc_pwm_pkg::ERR_LOCKED; // RQ20
          end else begin
            cmd_wr.en = answer;
          end
        end
        default: begin
          answer = rx_len >= nfc_pwm_pkg::LEN_SHORT;
          err    = nfc_pwm_pkg::ERR_UNSUP;
        end
      endcase
      if (err != 8'h00) begin // RQ18
        resp_bytes = nfc_pwm_pkg::RESP_ERR;
        resp_buf   = {72'h0, err, nfc_pwm_pkg::FLAG_ERR};
      end
    end
  end

  // ---------------------------------------------
  // answer transmitter
  // ---------------------------------------------
  logic [87:0] tx_buf;
  logic [6:0]  tx_left;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quiet     <= 1'b0;
      tx_buf    <= '0;
      tx_left   <= '0;
      resp_en   <= 1'b0;
      resp_data <= 1'b0;
    end else if (!in_config) begin // RQ7
      quiet     <= 1'b0;
      tx_left   <= '0;
      resp_en   <= 1'b0;
      resp_data <= 1'b0;
    end else begin
      quiet <= set_quiet | (quiet & ~clr_quiet);
      if (answer) begin
        tx_buf  <= resp_buf;
        tx_left <= {resp_bytes, 3'h0};
        resp_en <= 1'b1;
      end else if (resp_en && link_rise) begin
        resp_data <= tx_buf[0];
        tx_buf    <= tx_buf >> 1;
        tx_left   <= tx_left - 7'h1;
        resp_en   <= tx_left != 7'h0;
      end
    end
  end

  // ---------------------------------------------
  // bus slave
  // ---------------------------------------------
  logic [4:0] nvm_addr;
  wire req     = cyc_i & stb_i;
  wire wr_fire = req & we_i & ack_o;
  wire nvm_ok  = nvm_addr < 5'(nfc_pwm_pkg::NUM_BLOCKS);
  wire [31:0] rd_status = {27'h0, quiet, pwm_oe, lighting_mode,
                           config_mode, supply_ok};
  wire [31:0] rd_data =
    adr_i == nfc_pwm_pkg::REG_STATUS   ? rd_status :
    adr_i == nfc_pwm_pkg::REG_HOURS    ? hours :
    adr_i == nfc_pwm_pkg::REG_CYCLES   ?
      nvm[nfc_pwm_pkg::CYCLES_BLOCK] :
    adr_i == nfc_pwm_pkg::REG_SETPOINT ? {set_period, set_duty} :
    adr_i == nfc_pwm_pkg::REG_CTRL     ? {31'h0, aging_en} :
    adr_i == nfc_pwm_pkg::REG_NVM_ADDR ? {27'h0, nvm_addr} :
    adr_i == nfc_pwm_pkg::REG_NVM_DATA && nvm_ok ? nvm[nvm_addr] :
    32'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_o    <= 1'b0;
      dat_o    <= '0;
      aging_en <= nfc_pwm_pkg::CTRL_RESET;
      nvm_addr <= '0;
    end else begin
      ack_o <= req & ~ack_o;
      dat_o <= rd_data;
      if (wr_fire && sel_i[0] && adr_i == nfc_pwm_pkg::REG_CTRL) begin
        aging_en <= dat_i[0];
      end
      if (wr_fire && sel_i[0] && adr_i == nfc_pwm_pkg::REG_NVM_ADDR) begin
        nvm_addr <= dat_i[4:0];
      end
    end
  end
endmodule
`default_nettype wire

/* design/nfc_pwm_pkg.sv */
// What this block does
// RQ1: config mode only if field precedes supply
// RQ2: leave config mode when field drops
// RQ3: reader drops field before supply returns
// RQ4: pwm output disabled, high-z in config
// RQ5: lighting whenever supply present, config inactive
// RQ6: boot loads period and duty from memory
// RQ7: lighting mode ignores every reader frame
// RQ8: pwm frequency programmable 1 to 30 kHz
// RQ9: duty 0 to 100 percent, constant extremes
// RQ10: hours counted, saved every four hours
// RQ11: undervoltage saves hours before shutdown
// RQ12: power cycles counted and kept persistently
// RQ13: aging interpolates duty over eight points
// RQ14: reduced variant omits aging, build option
// RQ15: invalid frame length gets no answer
// RQ16: eight standard command codes accepted
// RQ17: custom A0h command with 90h sub-code
// RQ18: only error codes 01h,0Fh,10h,12h
// RQ19: user area is 13 four-byte blocks
// RQ20: locked blocks reject all later writes
// RQ21: carrier clock in config, oscillator lighting
// RQ22: pwm runs only in lighting mode
// RQ23: period counter, high below duty threshold
// RQ24: prescaler hour ticks raise save requests
package nfc_pwm_pkg;
  // ---------------------------------------------
  // memory layout
  // ---------------------------------------------
  localparam int           NUM_BLOCKS   = 18;
  localparam logic [7:0]   USER_BLOCKS  = 8'h0D;
  localparam logic [4:0]   CFG_BLOCK    = 5'h00;
  localparam logic [4:0]   REF_BASE     = 5'h01;
  localparam int           NUM_REFS     = 8;
  localparam logic [4:0]   HOURS_BLOCK  = 5'h09;
  localparam logic [4:0]   CYCLES_BLOCK = 5'h0A;
  localparam logic [4:0]   UID_LO       = 5'h0D;
  localparam logic [4:0]   UID_HI       = 5'h0E;
  localparam logic [4:0]   AFI_BLOCK    = 5'h0F;
  localparam logic [7:0]   LOCK_BLOCK   = 8'h11;
  localparam logic [31:0]  AFI_LOCK     = 32'h4000_0000;
  // ---------------------------------------------
  // commands, flags, errors, frame lengths
  // ---------------------------------------------
  localparam logic [7:0] CMD_INVENTORY = 8'h01;
  localparam logic [7:0] CMD_QUIET     = 8'h02;
  localparam logic [7:0] CMD_READ      = 8'h20;
  localparam logic [7:0] CMD_WRITE     = 8'h21;
  localparam logic [7:0] CMD_SELECT    = 8'h25;
  localparam logic [7:0] CMD_READY     = 8'h26;
  localparam logic [7:0] CMD_WR_AFI    = 8'h27;
  localparam logic [7:0] CMD_LOCK_AFI  = 8'h28;
  localparam logic [7:0] CMD_CUSTOM    = 8'hA0;
  localparam logic [7:0] SUB_BYTE_WR   = 8'h90;
  localparam logic [7:0] FLAG_OK       = 8'h00;
  localparam logic [7:0] FLAG_ERR      = 8'h01;
  localparam logic [7:0] ERR_UNSUP     = 8'h01;
  localparam logic [7:0] ERR_OTHER     = 8'h0F;
  localparam logic [7:0] ERR_NO_BLOCK  = 8'h10;
  localparam logic [7:0] ERR_LOCKED    = 8'h12;
  localparam logic [7:0] DSFID         = 8'h00;
  localparam logic [3:0] LEN_SHORT     = 4'h2;
  localparam logic [3:0] LEN_ONE_PARAM = 4'h3;
  localparam logic [3:0] LEN_BYTE_WR   = 4'h6;
  localparam logic [3:0] LEN_BLOCK_WR  = 4'h7;
  localparam logic [3:0] RESP_INV      = 4'hA;
  localparam logic [3:0] RESP_READ     = 4'h5;
  localparam logic [3:0] RESP_ERR      = 4'h2;
  localparam logic [3:0] RESP_OK       = 4'h1;
  localparam logic [6:0] RX_MAX_BITS   = 7'h40;
  // ---------------------------------------------
  // bus registers
  // ---------------------------------------------
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_HOURS    = 8'h04;
  localparam logic [7:0] REG_CYCLES   = 8'h08;
  localparam logic [7:0] REG_SETPOINT = 8'h0C;
  localparam logic [7:0] REG_CTRL     = 8'h10;
  localparam logic [7:0] REG_NVM_ADDR = 8'h14;
  localparam logic [7:0] REG_NVM_DATA = 8'h18;
  localparam logic       CTRL_RESET   = 1'b1;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint HOUR_S          = 3600;
  localparam logic [63:0] HOUR_CYCLES_DEF = 64'(CLK_HZ * HOUR_S);
  localparam int     SAVE_INTERVAL_HOURS = 4;
  localparam int     PWM_TICK_CYCLES = 2;
  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF, MODE_CONFIG, MODE_BOOT, MODE_LIGHT, MODE_SAVE
  } mode_t;
  typedef struct packed {
    logic clk;
    logic frame;
    logic data;
  } link_in_t;
  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic [31:0] data;
  } mem_wr_t;
endpackage

/* design/pwm_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_gen #(
  parameter int W    = 16,
  parameter int TICK = nfc_pwm_pkg::PWM_TICK_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] duty,
  output var  logic         pwm_out
);
  logic [W-1:0] cnt;
  logic [W-1:0] per_q;
  logic [W-1:0] duty_q;
  logic [7:0]   tick_cnt;
  // at 100 MHz with a two-cycle tick, 16 bits span 1 kHz .. 30 kHz
  wire tick   = tick_cnt == 8'(TICK - 1);
  wire at_end = {1'b0, cnt} + 1'b1 >= {1'b0, per_q}; // RQ8
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt      <= '0;
      per_q    <= '0;
      duty_q   <= '0;
      tick_cnt <= '0;
      pwm_out  <= 1'b0;
    end else if (!run) begin // RQ22
      cnt      <= '0;
      per_q    <= period;
      duty_q   <= duty;
      tick_cnt <= '0;
      pwm_out  <= 1'b0;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      // new setpoints only at a period boundary, no glitched pulse
      if (tick && at_end) begin
        cnt    <= '0;
        per_q  <= period;
        duty_q <= duty;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
      pwm_out <= cnt < duty_q; // RQ23 RQ9
    end
  end
endmodule
`default_nettype wire

/* verification/nfc_config_pwm_mode_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_config_pwm_mode_controller_tb_top;
  logic                  clk, reset, module_supply, field_present;
  logic                  cyc_i, stb_i, we_i, resp_data, resp_en, ack_o;
  logic                  pwm_out, pwm_oe, config_mode, lighting_mode;
  logic [7:0]            adr_i;
  logic [3:0]            sel_i;
  logic [31:0]           dat_i, dat_o, q;
  logic [39:0]           h;
  nfc_pwm_pkg::link_in_t link;
  int                    miscompares, checked;
  nfc_pwm_mode_ctrl #(.HOUR_CYCLES(64'h32)) dut (.clk(clk), .reset(reset),
    .module_supply(module_supply), .field_present(field_present),
    .link_in(link), .resp_data(resp_data), .resp_en(resp_en),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .config_mode(config_mode),
    .lighting_mode(lighting_mode), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o));
  reader_model rd (.clk(clk), .resp_data(resp_data), .resp_en(resp_en),
    .link_in(link));
  always #5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
    adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    do @(posedge clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic resp(input logic [63:0] r, input int nb, input int ne,
                      input logic [39:0] ev);
    rd.xfer({r[55:0], 8'h00}, nb);
    chk(40'(rd.nrx), 40'(ne));
    chk(rd.rx[39:0], ev);
  endtask
  task automatic config_test();
    field_present <= 1'b1;
    repeat (10) @(posedge clk);
    chk(40'(config_mode), 40'h1);
    chk(40'(pwm_oe), 40'h0);
    wb(1'b1, nfc_pwm_pkg::REG_CTRL, 32'h0);
    resp(48'h0010_0004_00_21, 56, 8, 0);
    resp(16'h20, 24, 40, 40'h0010_0004_00);
    resp(16'h12_20, 24, 16, 40'h10_01);
    resp(48'h0D_21, 56, 16, 40'h10_01);
    resp(48'h4_11_21, 56, 8, 0);
    resp(48'h01_21, 56, 16, 40'h12_01);
    resp(40'h55_00_02_90_A0, 48, 8, 0);
    resp(16'h02_20, 24, 40, 40'h55_00);
    resp(40'h55_04_02_90_A0, 48, 16, 40'h0F_01);
    resp(40'h55_00_02_91_A0, 48, 16, 40'h01_01);
    resp(8'h2B, 16, 16, 40'h01_01);
    resp(24'h20, 32, 0, 0);
    resp(16'h20, 20, 0, 0);
    resp(16'h01, 24, 80, 0);
    resp(8'h25, 16, 8, 0);
    resp(8'h26, 16, 8, 0);
    resp(16'h07_27, 24, 8, 0);
    resp(8'h28, 16, 8, 0);
    resp(8'h02, 16, 0, 0);
    resp(16'h01, 24, 0, 0);
  endtask
  task automatic light_test();
    field_present <= 1'b0;
    repeat (10) @(posedge clk);
    chk(40'(config_mode), 40'h0);
    module_supply <= 1'b1;
    repeat (20) @(posedge clk);
    chk(40'({lighting_mode, pwm_oe}), 40'h3);
    h = '0;
    // period 16 ticks of 2 clk, high for 4 ticks
    repeat (64) begin
      @(posedge clk);
      h = h + 40'(pwm_out);
    end
    chk(h, 40'h10);
    field_present <= 1'b1;
    resp(16'h20, 24, 0, 0);
    chk(40'(config_mode), 40'h0);
    field_present <= 1'b0;
    repeat (10) @(posedge clk);
    module_supply <= 1'b0;
    repeat (20) @(posedge clk);
    chk(40'({lighting_mode, pwm_out}), 40'h0);
    wb(1'b0, nfc_pwm_pkg::REG_CYCLES, 32'h0);
    chk(40'(q), 40'h1);
    wb(1'b0, nfc_pwm_pkg::REG_HOURS, 32'h0);
    chk(40'(q != 32'h0), 40'h1);
    h = 40'(q);
    wb(1'b1, nfc_pwm_pkg::REG_NVM_ADDR, 32'h9);
    wb(1'b0, nfc_pwm_pkg::REG_NVM_DATA, 32'h0);
    chk(40'(q), h);
    wb(1'b0, 8'hFC, 32'h0);
    chk(40'(q), 40'h0);
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0; reset = 1'b1; module_supply = 1'b0; field_present = 1'b0;
    cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00;
    sel_i = 4'h0; dat_i = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    config_test();
    light_test();
    complete_run();
  end
  initial begin
    #1ms;
    miscompares++;
    complete_run();
  end
endmodule
bind nfc_pwm_mode_ctrl nfc_pwm_mode_ctrl_asserts u_asserts (.clk(clk),
  .reset(reset), .module_supply(module_supply),
  .field_present(field_present), .resp_en(resp_en), .pwm_out(pwm_out),
  .pwm_oe(pwm_oe), .config_mode(config_mode),
  .lighting_mode(lighting_mode));
`default_nettype wire

/* verification/nfc_pwm_mode_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_pwm_mode_ctrl_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic module_supply,
  input wire logic field_present,
  input wire logic resp_en,
  input wire logic pwm_out,
  input wire logic pwm_oe,
  input wire logic config_mode,
  input wire logic lighting_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_cfg_pin_hiz: assert property (config_mode |-> !pwm_oe)
    else $error("pwm driven in config");
  a_pwm_idle_low: assert property (!lighting_mode |-> !pwm_out)
    else $error("pwm toggles outside lighting");
  a_light_silent: assert property (lighting_mode |-> !resp_en)
    else $error("answer in lighting");
  a_modes_apart: assert property (!(config_mode && lighting_mode))
    else $error("both modes active");
  a_cfg_entry: assert property ($rose(config_mode) |->
    $past(field_present, 2) && !$past(module_supply, 2))
    else $error("config entered wrongly");
  a_cfg_exit: assert property (!field_present [*5] |-> !config_mode)
    else $error("config kept without field");
  a_light_entry: assert property ($rose(module_supply) && !config_mode
    && !field_present |-> ##[1:12] lighting_mode)
    else $error("lighting not entered");
  a_power_off: assert property ($fell(module_supply)
    |-> ##[1:12] !lighting_mode)
    else $error("lighting kept after power off");
  cover property ($rose(config_mode));
  cover property ($rose(lighting_mode));
  cover property ($rose(resp_en));
endmodule
`default_nettype wire

/* verification/reader_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reader_model (
  input  wire logic                  clk,
  input  wire logic                  resp_data,
  input  wire logic                  resp_en,
  output var  nfc_pwm_pkg::link_in_t link_in
);
  logic [79:0] rx;
  int          nrx;
  initial link_in = '0;
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  task automatic xfer(input logic [63:0] req, input int nb);
    nrx = 0;
    rx = '0;
    link_in.frame <= 1'b1;
    for (int i = 0; i < nb; i++) begin
      link_in.data <= req[i];
      half();
      link_in.clk <= 1'b1;
      half();
      link_in.clk <= 1'b0;
    end
    link_in.frame <= 1'b0;
    link_in.data  <= ~link_in.data;
    for (int i = 0; i < 90; i++) begin
      half();
      link_in.clk <= 1'b1;
      half();
      link_in.clk <= 1'b0;
      if (resp_en === 1'b1 && nrx < 80) begin
        rx[nrx] = resp_data;
        nrx++;
      end
    end
  endtask
endmodule
`default_nettype wire
